// ==== verilog/dofm_pkg.sv ====
package dofm_pkg;
    localparam int NUM_PORTS = 6;
    localparam int NUM_RELAY = 2;
    localparam logic [7:0] CODE_INV_BASE = 8'h64;
    localparam logic [7:0] CODE_MAX = 8'h0F;
    localparam logic [7:0] CODE_INV_MAX = 8'h73;
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_READY = 8'h01;
    localparam logic [7:0] CODE_FAULT = 8'h02;
    localparam logic [7:0] CODE_RUN = 8'h03;
    localparam logic [7:0] CODE_ZSPEED = 8'h06;
    localparam logic [7:0] CODE_BUS = 8'h07;
    localparam logic [7:0] CODE_CURLVL = 8'h08;
    localparam logic [7:0] CODE_LEARN = 8'h09;
    localparam logic [7:0] CODE_FDET1 = 8'h0A;
    localparam logic [7:0] CODE_FDET2 = 8'h0B;
    localparam logic [7:0] CODE_PREDICT = 8'h0C;
    localparam logic [7:0] CODE_ALARM = 8'h0D;
    localparam logic [7:0] CODE_SERVO = 8'h0E;
    localparam logic [7:0] CODE_NZCUR = 8'h0F;
    // reset codes: relay0, relay1, coll0..coll3
    localparam logic [7:0] RST_CODE_RELAY = 8'h00;
    localparam logic [7:0] RST_CODE_COLL0 = 8'h03;
    localparam logic [7:0] RST_CODE_COLL1 = 8'h02;
    localparam logic [7:0] RST_CODE_COLLX = 8'h00;
    // threshold in 0.1 percent, frequencies in 0.01 Hz
    localparam logic [15:0] RST_NZ_THRESH = 16'h0014;
    localparam logic [15:0] MAX_NZ_THRESH = 16'h03E8;
    localparam logic [15:0] RST_FD_SPEED = 16'h0064;
    localparam logic [15:0] MAX_FD_SPEED = 16'h1770;
    localparam logic [15:0] RST_FD_WIDTH = 16'h0014;
    localparam logic [15:0] MAX_FD_WIDTH = 16'h07D0;
    localparam logic [15:0] PCT_DIV = 16'h03E8;
    localparam logic [15:0] PCT_RUN = 16'h0005;
    localparam logic [15:0] PCT_STOP = 16'h000A;
    localparam logic [15:0] PCT_UNIT = 16'h0064;
    // register map, byte addresses
    localparam logic [7:0] ADDR_CODE0 = 8'h00;
    localparam logic [7:0] ADDR_NZ = 8'h18;
    localparam logic [7:0] ADDR_FDS = 8'h1C;
    localparam logic [7:0] ADDR_FDW = 8'h20;
    localparam logic [7:0] ADDR_STAT = 8'h24;
endpackage

// ==== verilog/dofm_mapper.sv ====
`timescale 1ns/1ps
module dofm_mapper #(
    parameter int CW = 16
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // drive status
    input wire logic selfCheckOk,
    input wire logic faultEvent,
    input wire logic faultReset,
    input wire logic upCmd,
    input wire logic downCmd,
    input wire logic baseBlock,
    input wire logic busVoltOk,
    input wire logic selfLearn,
    input wire logic faultPredict,
    input wire logic alarmActive,
    input wire logic servoHeavy,
    input wire logic [15:0] outFreq,
    input wire logic [CW-1:0] outCurrent,
    input wire logic [CW-1:0] ratedCurrent,
    // output terminals
    output logic [1:0] relayEnergize,
    output logic [3:0] collectorOut,
    output logic [3:0] collectorOe,
    output logic runStatus,
    output logic faultStatus
);
    typedef enum logic [1:0] {WR_IDLE, WR_RESP} dofm_wr_t;

    logic [7:0] code_reg [6];
    logic [15:0] nzThresh_reg, fdSpeed_reg, fdWidth_reg;
    logic fdet1_reg, fdet2_reg;
    logic [5:0] port_reg, portNext;
    logic awHeld_reg, wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    dofm_wr_t wrState_reg;
    logic running;
    logic zeroSpeed;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // scaled current compare: cur*PCT_UNIT > rated*pct
    function automatic logic curAbove(input logic [CW-1:0] cur,
        input logic [CW-1:0] rat, input logic [15:0] pct);
        logic [CW+15:0] lhs;
        logic [CW+15:0] rhs;
        lhs = (CW+16)'(cur) * (CW+16)'(dofm_pkg::PCT_UNIT);
        rhs = (CW+16)'(rat) * (CW+16)'(pct);
        return lhs > rhs;
    endfunction

    function automatic logic [15:0] clampVal(input logic [31:0] v,
        input logic [15:0] mx);
        return (v > 32'(mx)) ? mx : v[15:0];
    endfunction

    assign running = runStatus;
    assign zeroSpeed = outFreq == 16'h0000;

    // run and fault status
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            runStatus <= 1'b0;
            faultStatus <= 1'b0;
        end else if (clkEn) begin
            if (faultEvent) begin
                faultStatus <= 1'b1;
            end else if (faultReset) begin
                faultStatus <= 1'b0;
            end
            runStatus <= (upCmd | downCmd) & ~baseBlock & ~faultEvent
                & ~faultStatus;
        end
    end

    // frequency detectors with hysteresis
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            fdet1_reg <= 1'b0;
            fdet2_reg <= 1'b0;
        end else if (clkEn) begin
            if (17'(outFreq) >= 17'(fdSpeed_reg) + 17'(fdWidth_reg)) begin
                fdet1_reg <= 1'b1;
            end else if (outFreq <= fdSpeed_reg) begin
                fdet1_reg <= 1'b0;
            end
            if (outFreq >= fdSpeed_reg) begin
                fdet2_reg <= 1'b1;
            end else if (17'(outFreq) + 17'(fdWidth_reg)
                    <= 17'(fdSpeed_reg)) begin
                fdet2_reg <= 1'b0;
            end
        end
    end

    // per-port function select
    always_comb begin
        logic [7:0] c;
        logic inv;
        logic cond;
        c = 8'h00;
        inv = 1'b0;
        cond = 1'b0;
        portNext = 6'b00_0000;
        for (int i = 0; i < dofm_pkg::NUM_PORTS; i++) begin
            c = code_reg[i];
            inv = 1'b0;
            if (c > dofm_pkg::CODE_INV_BASE) begin
                c = c - dofm_pkg::CODE_INV_BASE;
                inv = 1'b1;
            end
            case (c)
                dofm_pkg::CODE_READY: cond = selfCheckOk & ~faultStatus;
                dofm_pkg::CODE_FAULT: cond = faultStatus & ~running;
                dofm_pkg::CODE_RUN: cond = running;
                dofm_pkg::CODE_ZSPEED: cond = running & zeroSpeed;
                dofm_pkg::CODE_BUS: cond = busVoltOk;
                dofm_pkg::CODE_CURLVL: cond = running
                    ? curAbove(outCurrent, ratedCurrent, dofm_pkg::PCT_RUN)
                    : curAbove(outCurrent, ratedCurrent, dofm_pkg::PCT_STOP);
                dofm_pkg::CODE_LEARN: cond = selfLearn;
                dofm_pkg::CODE_FDET1: cond = ~fdet1_reg;
                dofm_pkg::CODE_FDET2: cond = fdet2_reg;
                dofm_pkg::CODE_PREDICT: cond = faultPredict;
                dofm_pkg::CODE_ALARM: cond = alarmActive & ~faultStatus;
                dofm_pkg::CODE_SERVO: cond = servoHeavy;
                dofm_pkg::CODE_NZCUR: cond = ~running
                    & curAbove(outCurrent, ratedCurrent,
                    nzThresh_reg / 16'h000A);
                default: begin
                    cond = 1'b0;
                    inv = 1'b0;
                end
            endcase
            portNext[i] = cond ^ inv;
        end
    end

    // registered terminals
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            port_reg <= 6'b00_0000;
            relayEnergize <= 2'b00;
            collectorOut <= 4'h0;
            collectorOe <= 4'h0;
        end else if (clkEn) begin
            port_reg <= portNext;
            relayEnergize <= portNext[1:0];
            collectorOut <= 4'h0;
            collectorOe <= portNext[5:2];
        end
    end

    // axi write channel
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            wrState_reg <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (clkEn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            case (wrState_reg)
                WR_IDLE: begin
                    if (s_axi_awvalid && !awHeld_reg && !s_axi_awready) begin
                        awHeld_reg <= 1'b1;
                        awAddr_reg <= s_axi_awaddr;
                        s_axi_awready <= 1'b1;
                    end
                    if (s_axi_wvalid && !wHeld_reg && !s_axi_wready) begin
                        wHeld_reg <= 1'b1;
                        wData_reg <= s_axi_wdata;
                        s_axi_wready <= 1'b1;
                    end
                    if (awHeld_reg && wHeld_reg) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (awAddr_reg > dofm_pkg::ADDR_STAT)
                            ? 2'b10 : 2'b00;
                        wrState_reg <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        awHeld_reg <= 1'b0;
                        wHeld_reg <= 1'b0;
                        wrState_reg <= WR_IDLE;
                    end
                end
                default: wrState_reg <= WR_IDLE;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            code_reg[0] <= dofm_pkg::RST_CODE_RELAY;
            code_reg[1] <= dofm_pkg::RST_CODE_RELAY;
            code_reg[2] <= dofm_pkg::RST_CODE_COLL0;
            code_reg[3] <= dofm_pkg::RST_CODE_COLL1;
            code_reg[4] <= dofm_pkg::RST_CODE_COLLX;
            code_reg[5] <= dofm_pkg::RST_CODE_COLLX;
            nzThresh_reg <= dofm_pkg::RST_NZ_THRESH;
            fdSpeed_reg <= dofm_pkg::RST_FD_SPEED;
            fdWidth_reg <= dofm_pkg::RST_FD_WIDTH;
        end else if (clkEn && wrState_reg == WR_IDLE && awHeld_reg
                && wHeld_reg && s_axi_wstrb[0]) begin
            for (int i = 0; i < dofm_pkg::NUM_PORTS; i++) begin
                if (awAddr_reg == 8'(i * 4)) begin
                    code_reg[i] <= wData_reg[7:0];
                end
            end
            case (awAddr_reg)
                dofm_pkg::ADDR_NZ: nzThresh_reg <= clampVal(wData_reg,
                    dofm_pkg::MAX_NZ_THRESH);
                dofm_pkg::ADDR_FDS: fdSpeed_reg <= clampVal(wData_reg,
                    dofm_pkg::MAX_FD_SPEED);
                dofm_pkg::ADDR_FDW: fdWidth_reg <= clampVal(wData_reg,
                    dofm_pkg::MAX_FD_WIDTH);
                default: begin
                end
            endcase
        end
    end

    // axi read channel
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (clkEn) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr)
                    dofm_pkg::ADDR_NZ: s_axi_rdata <= {16'h0000, nzThresh_reg};
                    dofm_pkg::ADDR_FDS: s_axi_rdata <= {16'h0000, fdSpeed_reg};
                    dofm_pkg::ADDR_FDW: s_axi_rdata <= {16'h0000, fdWidth_reg};
                    dofm_pkg::ADDR_STAT: s_axi_rdata <= {22'h00_0000,
                        fdet2_reg, fdet1_reg, port_reg, faultStatus, runStatus};
                    default: begin
                        if (s_axi_araddr < dofm_pkg::ADDR_NZ
                                && s_axi_araddr[1:0] == 2'b00) begin
                            s_axi_rdata <= {24'h00_0000,
                                code_reg[s_axi_araddr[4:2]]};
                        end else begin
                            s_axi_rresp <= 2'b10;
                        end
                    end
                endcase
            end
        end
    end

    sequence s_run_coded;
        clkEn && code_reg[2] == dofm_pkg::CODE_RUN;
    endsequence

    sequence s_fd1_clear;
        clkEn && outFreq <= fdSpeed_reg
            && 17'(outFreq) < 17'(fdSpeed_reg) + 17'(fdWidth_reg);
    endsequence

    sequence s_fd1_between;
        clkEn && outFreq > fdSpeed_reg
            && 17'(outFreq) < 17'(fdSpeed_reg) + 17'(fdWidth_reg);
    endsequence

    sequence s_fd2_clear;
        clkEn && outFreq < fdSpeed_reg
            && 17'(outFreq) + 17'(fdWidth_reg) <= 17'(fdSpeed_reg);
    endsequence

    sequence s_fd2_between;
        clkEn && outFreq < fdSpeed_reg
            && 17'(outFreq) + 17'(fdWidth_reg) > 17'(fdSpeed_reg);
    endsequence

    a_run_needs_cmd: assert property (
        clkEn ##1 runStatus |-> $past(upCmd | downCmd) && !$past(baseBlock))
        else $error("run without command");

    a_fault_clears_run: assert property (
        clkEn && faultEvent |=> faultStatus && !runStatus)
        else $error("fault did not latch");

    a_fault_holds: assert property (
        clkEn && faultStatus && !faultReset |=> faultStatus)
        else $error("fault released early");

    a_fdet1_sets: assert property (
        clkEn && 17'(outFreq) >= 17'(fdSpeed_reg) + 17'(fdWidth_reg)
        |=> fdet1_reg) else $error("detector one missed");

    a_fdet1_clears: assert property (
        s_fd1_clear |=> !fdet1_reg)
        else $error("detector one stuck");

    a_fdet1_holds: assert property (
        s_fd1_between |=> $stable(fdet1_reg))
        else $error("detector one moved");

    a_fdet2_sets: assert property (
        clkEn && outFreq >= fdSpeed_reg |=> fdet2_reg)
        else $error("detector two missed");

    a_fdet2_clears: assert property (
        s_fd2_clear |=> !fdet2_reg)
        else $error("detector two stuck");

    a_fdet2_holds: assert property (
        s_fd2_between |=> $stable(fdet2_reg))
        else $error("detector two moved");

    a_oc_low_only: assert property (
        collectorOut == 4'h0)
        else $error("collector driven high");

    a_relay_follows: assert property (
        clkEn |=> relayEnergize == $past(portNext[1:0]))
        else $error("relay level wrong");

    a_port_follows: assert property (
        clkEn |=> collectorOe == $past(portNext[5:2]))
        else $error("collector level wrong");

    a_bad_code_off: assert property (
        clkEn && (code_reg[0] > dofm_pkg::CODE_INV_MAX
        || code_reg[0] == dofm_pkg::CODE_NONE) |=> !relayEnergize[0])
        else $error("bad code asserted");

    a_fault_maps: assert property (
        clkEn && code_reg[3] == dofm_pkg::CODE_FAULT
        |=> collectorOe[1] == $past(faultStatus && !runStatus))
        else $error("fault port wrong");

    a_run_maps: assert property (
        s_run_coded ##1 clkEn |-> collectorOe[0] == $past(runStatus))
        else $error("run port wrong");
endmodule // dofm_mapper

// ==== tb/dofm_term_model.sv ====
`timescale 1ns/1ps
module dofm_term_model (
    // terminals driven by the mapper
    input wire logic [1:0] relayEnergize,
    input wire logic [3:0] collectorOut,
    input wire logic [3:0] collectorOe,
    // contact and line state seen by the controller
    output logic [1:0] noClosed,
    output logic [1:0] ncClosed,
    output logic [3:0] lineLevel,
    output logic [5:0] portOn
);
    // relay: energized closes the normally open pair
    assign noClosed = relayEnergize;
    assign ncClosed = ~relayEnergize;
    // collector lines carry a pull-up, so a released line reads high
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lineLevel[i] = collectorOe[i] ? collectorOut[i] : 1'b1;
        end
    end
    // controller sees a collector port as on when its line is low
    assign portOn = {~lineLevel, noClosed};
endmodule // dofm_term_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bRdy = 1'b0, arv = 1'b0, rRdy = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic awr, wr, bv, arr, rv;
    logic [1:0] br, rr;
    logic [31:0] rd;
    logic [10:0] st = 11'h000;
    logic [15:0] freq = 16'h0000, cur = 16'h0000, rated = 16'h03E8;
    logic [1:0] relayEnergize;
    logic [3:0] collectorOut, collectorOe;
    logic runStatus, faultStatus;
    logic [5:0] portOn;
    integer numErrors = 0, nChecks = 0, seed = 32'hdade_bf38;
    logic ce = 1'b1;
    logic [3:0] ws = 4'hF;
    logic fM = 1'b0, d1M = 1'b0, d2M = 1'b0;
    logic [15:0] spM = 16'h0064, wdM = 16'h0014, thM = 16'h0014;
    logic [7:0] codes [6];

    always #12.5 sys_clk = ~sys_clk;

    dofm_mapper #(.CW(16)) u_dofm_mapper (
        .sys_clk(sys_clk), .nrst(nrst), .clkEn(ce),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bRdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rRdy),
        .selfCheckOk(st[0]), .faultEvent(st[1]), .faultReset(st[2]),
        .upCmd(st[3]), .downCmd(st[4]), .baseBlock(st[5]),
        .busVoltOk(st[6]), .selfLearn(st[7]), .faultPredict(st[8]),
        .alarmActive(st[9]), .servoHeavy(st[10]), .outFreq(freq),
        .outCurrent(cur), .ratedCurrent(rated),
        .relayEnergize(relayEnergize), .collectorOut(collectorOut),
        .collectorOe(collectorOe), .runStatus(runStatus),
        .faultStatus(faultStatus)
    );

    dofm_term_model u_dofm_term_model (
        .relayEnergize(relayEnergize), .collectorOut(collectorOut),
        .collectorOe(collectorOe), .noClosed(), .ncClosed(),
        .lineLevel(), .portOn(portOn)
    );

    task automatic testDone;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chkVal(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
        nChecks++;
        if (g !== e) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkBit(input string nm, input logic e, input logic g);
        nChecks++;
        if (g !== e) begin
            numErrors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic hang(input string nm);
        numErrors++;
        $display("ERROR %s expected answer seen none", nm);
        testDone();
    endtask

    task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
        int k;
        @(posedge sys_clk);
        awa <= a;
        awv <= 1'b1;
        wd <= d;
        wv <= 1'b1;
        bRdy <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge sys_clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) break;
        end
        bRdy <= 1'b0;
        if (k == 100) hang("bvalid");
        chkVal("bresp", {30'h0, er}, {30'h0, br});
    endtask

    task automatic axiRd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
        int k;
        @(posedge sys_clk);
        ara <= a;
        arv <= 1'b1;
        rRdy <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge sys_clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rd;
        r = rr;
        rRdy <= 1'b0;
        if (k == 100) hang("rvalid");
    endtask

    function automatic logic expPort(input logic [7:0] code);
        logic c;
        logic runM;
        logic [7:0] b;
        runM = (st[3] | st[4]) & ~st[5] & ~fM;
        b = (code > 8'h64) ? code - 8'h64 : code;
        case (b)
            8'h01: c = st[0] & ~fM;
            8'h02: c = fM & ~runM;
            8'h03: c = runM;
            8'h06: c = runM & (freq == 16'h0000);
            8'h07: c = st[6];
            8'h08: c = 32'(cur) * 100 > 32'(rated) * (runM ? 5 : 10);
            8'h09: c = st[7];
            8'h0A: c = ~d1M;
            8'h0B: c = d2M;
            8'h0C: c = st[8];
            8'h0D: c = st[9] & ~fM;
            8'h0E: c = st[10];
            8'h0F: c = ~runM & (32'(cur) * 100 > 32'(rated) * (thM / 10));
            default: return 1'b0;
        endcase
        if (code > 8'h73) return 1'b0;
        return c ^ (code > 8'h64);
    endfunction

    // drive a random status set, hold it, then advance the bench model
    task automatic randIn(input int fv);
        logic [31:0] v;
        logic [10:0] r;
        v = $random(seed);
        r = v[10:0];
        r[1] = r[1] & v[11] & v[12];
        @(posedge sys_clk);
        st <= r;
        freq <= (fv >= 0) ? 16'(fv) : (v[13] ? 16'h0000 : {8'h00, v[31:24]});
        cur <= {8'h00, v[23:16]};
        rated <= 16'h03E8 + {6'h00, v[31:22]};
        repeat (4) @(posedge sys_clk);
        if (st[1]) fM = 1'b1;
        else if (st[2]) fM = 1'b0;
        if (freq >= spM + wdM) d1M = 1'b1;
        else if (freq <= spM) d1M = 1'b0;
        if (freq >= spM) d2M = 1'b1;
        else if (freq <= spM - wdM) d2M = 1'b0;
    endtask

    task automatic chkAll;
        logic runM;
        runM = (st[3] | st[4]) & ~st[5] & ~fM;
        chkBit("run", runM, runStatus);
        chkBit("fault", fM, faultStatus);
        for (int i = 0; i < 6; i++) begin
            chkBit("port", expPort(codes[i]), portOn[i]);
        end
    endtask

    initial begin
        int i, j;
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] snap;
        int fs [9] = '{0, 170, 179, 180, 175, 150, 140, 120, 0};
        logic [7:0] fc [4] = '{8'h0A, 8'h6E, 8'h0B, 8'h6F};
        codes = '{8'h00, 8'h00, 8'h03, 8'h02, 8'h00, 8'h00};
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        for (i = 0; i < 6; i++) begin
            axiRd(8'(4 * i), d, r);
            chkVal("code", {24'h0, codes[i]}, d);
        end
        axiRd(8'h18, d, r);
        chkVal("thresh", 32'h0000_0014, d);
        axiRd(8'h1C, d, r);
        chkVal("speed", 32'h0000_0064, d);
        axiRd(8'h20, d, r);
        chkVal("width", 32'h0000_0014, d);
        axiRd(8'h40, d, r);
        chkVal("rresp", 32'h0000_0002, {30'h0, r});
        axiWr(8'h40, 32'h0000_0001, 2'b10);
        chkAll();
        $display("test reset done");
        axiWr(8'h18, 32'h0000_0FFF, 2'b00);
        axiRd(8'h18, d, r);
        chkVal("thresh", 32'h0000_03E8, d);
        ws <= 4'h0;
        axiWr(8'h18, 32'h0000_0005, 2'b00);
        ws <= 4'hF;
        axiRd(8'h18, d, r);
        chkVal("thresh", 32'h0000_03E8, d);
        axiWr(8'h18, 32'h0000_001E, 2'b00);
        thM = 16'h001E;
        $display("test threshold done");
        for (j = 0; j < 33; j++) begin
            i = {$random(seed)} % 6;
            codes[i] = (j < 17) ? 8'(j) : 8'(j + 83);
            axiWr(8'(4 * i), {24'h0, codes[i]}, 2'b00);
            repeat (3) begin
                randIn(-1);
                chkAll();
            end
        end
        codes[0] = 8'hC8;
        axiWr(8'h00, 32'h0000_00C8, 2'b00);
        randIn(-1);
        chkAll();
        $display("test codes done");
        axiWr(8'h1C, 32'h0000_0096, 2'b00);
        axiWr(8'h20, 32'h0000_001E, 2'b00);
        spM = 16'h0096;
        wdM = 16'h001E;
        for (i = 0; i < 4; i++) begin
            codes[i] = fc[i];
            axiWr(8'(4 * i), {24'h0, fc[i]}, 2'b00);
        end
        foreach (fs[k]) begin
            randIn(fs[k]);
            chkAll();
        end
        $display("test detectors done");
        snap = {runStatus, faultStatus, portOn};
        @(posedge sys_clk);
        ce <= 1'b0;
        st <= ~st;
        repeat (4) @(posedge sys_clk);
        chkVal("frozen", {24'h0, snap},
               {24'h0, runStatus, faultStatus, portOn});
        st <= ~st;
        ce <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chkAll();
        $display("test freeze done");
        testDone();
    end
endmodule // tb_top
